//--- sbmc_core.sv
`include "sbmc_params.svh"
module sbmc_core
   import sbmc_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RST_N,
   // Special function register access
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   // Serial pins
   input  wire sbmc_pins_t PIN_I,
   output sbmc_pins_t      PIN_O,
   output sbmc_pins_t      PIN_OE,
   // Interrupt level
   output logic            SPI_IRQ
);
   localparam int DEPTH = `SBMC_FIFO_DEPTH;

   logic [7:0]  port_r, mode_r, rdata_r, rx_buf_r, sh_r;
   logic [7:0]  tx_mem [DEPTH];
   logic [7:0]  rx_mem [DEPTH];
   logic        tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
   logic [1:0]  tx_cnt_r, rx_cnt_r;
   sbmc_pins_t  s1_r, s2_r;
   logic        sclk_d_r, sclk_r;
   logic [3:0]  ph_r, bit_r;
   logic [4:0]  div_r;
   sbmc_state_t st_r;

   logic enabled, master, tx_empty, tx_full, rx_empty, rx_full;
   logic tx_push, tx_pop, rx_push, rx_pop;
   logic [7:0] rx_byte;
   logic tick, selected, s_rise, s_fall;
   logic [5:0] half_cnt;
   logic       m_bit_r;

   assign enabled  = port_r[`SBMC_PORT_EN];
   assign master   = port_r[`SBMC_PORT_MASTER];
   assign tx_empty = (tx_cnt_r == 2'h0);
   assign tx_full  = (tx_cnt_r == 2'(DEPTH));
   assign rx_empty = (rx_cnt_r == 2'h0);
   assign rx_full  = (rx_cnt_r == 2'(DEPTH));
   assign tx_push  = SFR_WR && (SFR_ADDR == `SBMC_ADDR_TX) && !tx_full;
   assign rx_pop   = SFR_RD && (SFR_ADDR == `SBMC_ADDR_RX) && !rx_empty;

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         port_r <= `SBMC_PORT_RESET;
         mode_r <= `SBMC_MODE_RESET;
      end
      else if (SFR_WR && SFR_ADDR == `SBMC_ADDR_PORT)
         port_r <= SFR_WDATA;
      else if (SFR_WR && SFR_ADDR == `SBMC_ADDR_MODE)
         mode_r <= SFR_WDATA & `SBMC_MODE_MASK;
   end

   // ****************************************
   // Read path
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_r  <= 8'h00;
         rx_buf_r <= 8'h00;
      end
      else if (SFR_RD)
      begin
         case (SFR_ADDR)
            `SBMC_ADDR_RX:
            begin
               // Empty FIFO re-reads the last byte instead of stale memory
               if (rx_pop)
               begin
                  rx_buf_r <= rx_mem[rx_rp_r];
                  rdata_r  <= rx_mem[rx_rp_r];
               end
               else
                  rdata_r <= rx_buf_r;
            end
            `SBMC_ADDR_PORT: rdata_r <= port_r;
            `SBMC_ADDR_MODE: rdata_r <= mode_r;
            default:         rdata_r <= 8'h00;
         endcase
      end
   end
   assign SFR_RDATA = rdata_r;

   // ****************************************
   // Transmit FIFO
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_wp_r  <= 1'b0;
         tx_rp_r  <= 1'b0;
         tx_cnt_r <= 2'h0;
      end
      else
      begin
         if (tx_push)
            tx_wp_r <= ~tx_wp_r;
         if (tx_pop)
            tx_rp_r <= ~tx_rp_r;
         tx_cnt_r <= tx_cnt_r + 2'(tx_push) - 2'(tx_pop);
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (tx_push)
         tx_mem[tx_wp_r] <= SFR_WDATA;
   end

   // ****************************************
   // Receive FIFO
   // ****************************************
   logic rx_take, rx_over;
   assign rx_take = rx_push && (!rx_full || rx_pop);
   assign rx_over = rx_push && rx_full && !rx_pop && mode_r[`SBMC_MODE_OVWR];

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rx_wp_r  <= 1'b0;
         rx_rp_r  <= 1'b0;
         rx_cnt_r <= 2'h0;
      end
      else
      begin
         if (rx_take)
            rx_wp_r <= ~rx_wp_r;
         if (rx_pop)
            rx_rp_r <= ~rx_rp_r;
         rx_cnt_r <= rx_cnt_r + 2'(rx_take) - 2'(rx_pop);
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (rx_take)
         rx_mem[rx_wp_r] <= rx_byte;
      else if (rx_over)
         rx_mem[~rx_wp_r] <= rx_byte;
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s1_r     <= '{default: 1'b1};
         s2_r     <= '{default: 1'b1};
         // Matches the reset level of the second stage, so no false edge
         sclk_d_r <= 1'b1;
      end
      else
      begin
         s1_r     <= PIN_I;
         s2_r     <= s1_r;
         sclk_d_r <= s2_r.sclk;
      end
   end

   assign s_rise   = s2_r.sclk && !sclk_d_r;
   assign s_fall   = !s2_r.sclk && sclk_d_r;
   assign selected = !mode_r[`SBMC_MODE_SSEN] || !s2_r.ss;

   // ****************************************
   // Master clock divider
   // ****************************************
   // Six bits so that the /64 half period of 32 does not wrap
   assign half_cnt = 6'h04 << mode_r[`SBMC_MODE_RATE_HI:0];
   assign tick     = ({1'b0, div_r} == half_cnt - 6'h01);

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
         div_r <= 5'h00;
      else if (st_r == SBMC_IDLE || tick)
         div_r <= 5'h00;
      else
         div_r <= div_r + 5'h01;
   end

   // ****************************************
   // Shift engine, master and slave
   // ****************************************
   logic m_start, m_done, s_done;
   assign m_start = enabled && master && st_r == SBMC_IDLE && !tx_empty;
   assign m_done  = st_r == SBMC_SHIFT && tick && ph_r == 4'hF;
   assign s_done  = enabled && !master && selected && s_rise && bit_r == 4'h7;
   assign tx_pop  = m_start
                  || (m_done && port_r[`SBMC_PORT_CONT] && !tx_empty)
                  || (enabled && !master && selected && s_rise && bit_r == 4'h0 && !tx_empty);
   assign rx_push = m_done || s_done;
   assign rx_byte = m_done ? {sh_r[6:0], m_bit_r} : {sh_r[6:0], s2_r.mosi};

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_r    <= SBMC_IDLE;
         sh_r    <= 8'h00;
         ph_r    <= 4'h0;
         bit_r   <= 4'h0;
         sclk_r  <= 1'b0;
         m_bit_r <= 1'b0;
      end
      else if (!enabled)
      begin
         st_r   <= SBMC_IDLE;
         ph_r   <= 4'h0;
         bit_r  <= 4'h0;
         sclk_r <= 1'b0;
      end
      else if (master)
      begin
         bit_r <= 4'h0;
         case (st_r)
            SBMC_IDLE:
            begin
               if (m_start)
               begin
                  sh_r <= tx_mem[tx_rp_r];
                  ph_r <= 4'h0;
                  st_r <= SBMC_SHIFT;
               end
            end
            SBMC_SHIFT:
            begin
               if (tick)
               begin
                  sclk_r <= ~sclk_r;
                  ph_r   <= ph_r + 4'h1;
                  // Sample on the rising edge, move MOSI on the falling edge
                  if (!sclk_r)
                     m_bit_r <= s2_r.miso;
                  else
                     sh_r <= {sh_r[6:0], m_bit_r};
                  if (m_done)
                  begin
                     // Back-to-back bytes keep select low when continuous
                     if (port_r[`SBMC_PORT_CONT] && !tx_empty)
                        sh_r <= tx_mem[tx_rp_r];
                     else
                        st_r <= SBMC_GAP;
                  end
               end
            end
            SBMC_GAP:
            begin
               if (tick)
                  st_r <= SBMC_IDLE;
            end
            default: st_r <= SBMC_IDLE;
         endcase
      end
      else
      begin
         st_r   <= SBMC_IDLE;
         sclk_r <= 1'b0;
         if (!selected)
            bit_r <= 4'h0;
         else if (s_rise)
         begin
            sh_r  <= (bit_r == 4'h0) ? {(tx_empty ? 7'h00 : tx_mem[tx_rp_r][6:0]), s2_r.mosi}
                                     : {sh_r[6:0], s2_r.mosi};
            bit_r <= (bit_r == 4'h7) ? 4'h0 : bit_r + 4'h1;
         end
         else if (bit_r == 4'h0)
            sh_r <= tx_empty ? 8'h00 : tx_mem[tx_rp_r];
      end
   end

   // ****************************************
   // Pin drive and interrupt
   // ****************************************
   logic ss_out;
   assign ss_out = mode_r[`SBMC_MODE_AUTOSS] ? (st_r != SBMC_SHIFT) : 1'b0;

   assign PIN_O.sclk  = sclk_r;
   assign PIN_O.mosi  = sh_r[7];
   assign PIN_O.miso  = sh_r[7];
   assign PIN_O.ss    = ss_out;
   assign PIN_OE.sclk = enabled && master;
   assign PIN_OE.mosi = enabled && master;
   assign PIN_OE.miso = enabled && !master && selected;
   assign PIN_OE.ss   = enabled && master;
   assign SPI_IRQ     = mode_r[`SBMC_MODE_IRQSRC] ? tx_empty : !rx_empty;

   // ****************************************
   // Checks
   // ****************************************
   tx_push_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      tx_push && !tx_pop |=> tx_cnt_r == $past(tx_cnt_r) + 2'h1)
      else $error("transmit write not queued");
   start_pop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m_start |=> st_r == SBMC_SHIFT
                  && tx_cnt_r == $past(tx_cnt_r) + 2'($past(tx_push)) - 2'h1)
      else $error("transfer did not take FIFO head");
   rx_pop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      rx_pop |=> SFR_RDATA == $past(rx_mem[rx_rp_r]))
      else $error("receive read did not present popped byte");
   rx_push_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      rx_push && !rx_full && !rx_pop |=> rx_cnt_r == $past(rx_cnt_r) + 2'h1)
      else $error("received byte not stored");
   irq_src_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !mode_r[`SBMC_MODE_IRQSRC] && !rx_empty |-> SPI_IRQ)
      else $error("receive interrupt missing");
   irq_tx_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      mode_r[`SBMC_MODE_IRQSRC] |-> SPI_IRQ == tx_empty)
      else $error("transmit interrupt wrong");
   manual_ss_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      enabled && master && !mode_r[`SBMC_MODE_AUTOSS] |-> PIN_OE.ss && !PIN_O.ss)
      else $error("manual select not low");
   auto_ss_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m_done && !port_r[`SBMC_PORT_CONT] && mode_r[`SBMC_MODE_AUTOSS] |=> PIN_O.ss)
      else $error("select not released after byte");
   cont_ss_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      m_done && port_r[`SBMC_PORT_CONT] && !tx_empty && mode_r[`SBMC_MODE_AUTOSS]
      |=> !PIN_O.ss)
      else $error("select released inside continuous transfer");
   discard_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      rx_push && rx_full && !rx_pop |=> rx_cnt_r == 2'(DEPTH) && $stable(rx_rp_r))
      else $error("overflow changed FIFO level");
   reserved_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      mode_r[7:6] == 2'h0)
      else $error("reserved bits set");
   disable_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !enabled |-> !PIN_OE.sclk && !PIN_OE.miso ##1 st_r == SBMC_IDLE)
      else $error("disabled port still active");
endmodule

//--- sbmc_params.svh
`ifndef SBMC_PARAMS_SVH
`define SBMC_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define SBMC_ADDR_TX       8'h9A
`define SBMC_ADDR_RX       8'h9B
`define SBMC_ADDR_PORT     8'hE8
`define SBMC_ADDR_MODE     8'hE9

// ****************************************
// Field positions and resets
// ****************************************
`define SBMC_PORT_CONT     7
`define SBMC_PORT_EN       6
`define SBMC_PORT_MASTER   4
`define SBMC_MODE_IRQSRC   5
`define SBMC_MODE_AUTOSS   4
`define SBMC_MODE_SSEN     3
`define SBMC_MODE_OVWR     2
`define SBMC_MODE_RATE_HI  1
`define SBMC_PORT_RESET    8'h10
`define SBMC_MODE_RESET    8'h10
`define SBMC_MODE_MASK     8'h3F
`define SBMC_FIFO_DEPTH    2
`endif

//--- sbmc_pkg.sv
package sbmc_pkg;
   typedef enum logic [2:0] {
      SBMC_IDLE  = 3'b001,
      SBMC_SHIFT = 3'b010,
      SBMC_GAP   = 3'b100
   } sbmc_state_t;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic ss;
   } sbmc_pins_t;
endpackage

//--- sbmc_slave_model.sv
module sbmc_slave_model
(
   // Serial side
   input  wire logic       sclk,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   // Test side, plus the serial MISO output
   input  wire logic [7:0] reply,
   output logic            miso,
   output logic [7:0]      got
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Mode 0 slave, MSB first
   // ****
   logic [7:0] sh = 8'h00;
   int         n = 0;
   initial miso = 1'b0;
   initial got = 8'h00;
   always @(negedge ss_n)
   begin
      sh = reply;
      n = 0;
      miso = reply[7];
   end
   always @(posedge sclk)
      if (!ss_n)
      begin
         got = {got[6:0], mosi};
         n++;
      end
   // Reload between chained bytes; ss may stay low
   always @(negedge sclk)
      if (!ss_n)
      begin
         sh = (n == 8) ? reply : {sh[6:0], 1'b0};
         n = (n == 8) ? 0 : n;
         miso = sh[7];
      end
   // Released line must not keep a plausible value
   always @(posedge ss_n)
      miso = ~miso;
endmodule

//--- sbmc_tb.sv
module tb
   import sbmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] rdata, got, rd_v;
   logic [7:0] reply = 8'h00;
   sbmc_pins_t pin_i, pin_o, pin_oe;
   logic       irq, m_miso, sclk_q, ss_q;
   logic       tb_sclk = 1'b0;
   logic       tb_mosi = 1'b0;
   logic       tb_ss = 1'b1;
   int         failures = 0;
   int         checks_done = 0;
   int         cyc = 0, last_r = 0, prev_r = 0, ss_rises = 0, n0;
   always #2.5 clk_sys = ~clk_sys;
   assign pin_i = {pin_oe.sclk ? pin_o.sclk : tb_sclk, pin_oe.mosi ? pin_o.mosi : tb_mosi,
                   pin_oe.miso ? pin_o.miso : m_miso, pin_oe.ss ? pin_o.ss : tb_ss};
   sbmc_core dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
      .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(rdata), .PIN_I(pin_i),
      .PIN_O(pin_o), .PIN_OE(pin_oe), .SPI_IRQ(irq));
   sbmc_slave_model u_slave (.sclk(pin_i.sclk), .ss_n(pin_i.ss), .mosi(pin_i.mosi),
      .reply(reply), .miso(m_miso), .got(got));
   // ****
   // Monitor and timeout
   // ****
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      sclk_q <= pin_i.sclk;
      ss_q <= pin_i.ss;
      if (pin_i.sclk && !sclk_q)
      begin
         prev_r <= last_r;
         last_r <= cyc;
      end
      if (pin_i.ss && !ss_q)
         ss_rises <= ss_rises + 1;
      if (cyc == 20000)
      begin
         $display("[FAIL] %0t timeout", $time);
         failures++;
         results();
      end
   end
   task results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a);
      tick(1);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick(1);
      sfr_rd = 1'b0;
      rd_v = rdata;
   endtask
   task wait_ss(input logic v);
      for (int i = 0; i < 3000 && pin_i.ss !== v; i++)
         tick(1);
   endtask
   task xfer(input logic [7:0] rep, input logic [7:0] tx);
      reply = rep;
      wr(8'h9A, tx);
      wait_ss(1'b0);
      wait_ss(1'b1);
      tick(2);
   endtask
   // ****
   // Scenarios
   // ****
   task t_regs;
      rd(8'hE8);
      chk(rd_v, 8'h10);
      rd(8'hE9);
      chk(rd_v, 8'h10);
      rd(8'h9B);
      chk(rd_v, 8'h00);
      rd(8'h80);
      chk(rd_v, 8'h00);
      chk(8'(pin_oe), 8'h00);
      chk(8'(irq), 8'h00);
      wr(8'hE9, 8'hFF);
      rd(8'hE9);
      chk(rd_v, 8'h3F);
      $display("t_regs done");
   endtask
   task t_master;
      wr(8'hE8, 8'h50);
      for (int r = 0; r < 4; r++)
      begin
         wr(8'hE9, 8'h10 + 8'(r));
         xfer(8'hC3 ^ 8'(r), 8'h3C ^ 8'(r));
         chk(8'(last_r - prev_r), 8'(8 << r));
         chk(got, 8'h3C ^ 8'(r));
         chk(8'(irq), 8'h01);
         rd(8'h9B);
         chk(rd_v, 8'hC3 ^ 8'(r));
         chk(8'(irq), 8'h00);
      end
      wr(8'hE9, 8'h00);
      tick(4);
      chk(8'(pin_i.ss), 8'h00);
      $display("t_master done");
   endtask
   task t_chain;
      for (int c = 0; c < 2; c++)
      begin
         wr(8'hE8, c ? 8'hD0 : 8'h50);
         wr(8'hE9, 8'h10);
         tick(2);
         n0 = ss_rises;
         wr(8'h9A, 8'h11);
         wr(8'h9A, 8'h22);
         tick(200);
         chk(8'(ss_rises - n0), c ? 8'h01 : 8'h02);
         chk(got, 8'h22);
         rd(8'h9B);
         rd(8'h9B);
      end
      $display("t_chain done");
   endtask
   task t_ovf;
      wr(8'hE8, 8'h50);
      for (int o = 0; o < 2; o++)
      begin
         wr(8'hE9, o ? 8'h14 : 8'h10);
         xfer(8'h11, 8'h01);
         xfer(8'h22, 8'h02);
         xfer(8'h33, 8'h03);
         rd(8'h9B);
         chk(rd_v, 8'h11);
         rd(8'h9B);
         chk(rd_v, o ? 8'h33 : 8'h22);
         chk(8'(irq), 8'h00);
      end
      $display("t_ovf done");
   endtask
   task t_irq_tx;
      wr(8'hE8, 8'h10);
      wr(8'hE9, 8'h30);
      chk(8'(irq), 8'h01);
      reply = 8'h77;
      wr(8'h9A, 8'h5A);
      chk(8'(irq), 8'h00);
      tick(20);
      chk(8'(pin_oe), 8'h00);
      wr(8'hE8, 8'h50);
      wait_ss(1'b0);
      wait_ss(1'b1);
      chk(got, 8'h5A);
      chk(8'(irq), 8'h01);
      rd(8'h9B);
      $display("t_irq_tx done");
   endtask
   task sbyte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
      begin
         tb_mosi = d[i];
         tick(4);
         tb_sclk = 1'b1;
         tick(4);
         tb_sclk = 1'b0;
      end
      tick(4);
   endtask
   task t_slave;
      wr(8'hE8, 8'h40);
      wr(8'hE9, 8'h18);
      tb_ss = 1'b0;
      tick(4);
      chk(8'(pin_oe.miso), 8'h01);
      sbyte(8'h96);
      tb_ss = 1'b1;
      tb_mosi = ~tb_mosi;
      sbyte(8'h69);
      rd(8'h9B);
      chk(rd_v, 8'h96);
      chk(8'(irq), 8'h00);
      $display("t_slave done");
   endtask
   initial
   begin
      tick(6);
      rst_n = 1'b1;
      t_regs();
      t_master();
      t_chain();
      t_ovf();
      t_irq_tx();
      t_slave();
      results();
   end
endmodule
